// ==== step_attenuator_pkg.sv ====
// Constants shared by the step attenuator control port.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port.
package step_attenuator_pkg;

  // ---------------------------------------------------------------
  // Attenuation word
  // ---------------------------------------------------------------
  localparam int ATTEN_W = 7;
  localparam logic [6:0] ATTEN_MAX = 7'h7F;
  localparam logic [6:0] ATTEN_MIN = 7'h00;

  // ---------------------------------------------------------------
  // Serial shift register layout
  // ---------------------------------------------------------------
  localparam int SHIFT_W = 16;
  localparam int ADDR_LSB = 8;
  localparam int STRAP_W = 3;

  // ---------------------------------------------------------------
  // Power-up timing
  // ---------------------------------------------------------------
  localparam int PUP_DELAY_US = 400;
  localparam int CLK_MHZ = 100;
  localparam int PUP_CYCLES = PUP_DELAY_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_FORCE_MAX = 0;
  localparam int STAT_MODE = 7;
  localparam int STAT_PUP_DONE = 8;
  localparam int STAT_ADDR_HIT = 9;
  localparam logic [31:0] WB_ZERO = 32'h0000_0000;

endpackage : step_attenuator_pkg

// ==== step_attenuator.sv ====
// Control port of a 7-bit step attenuator: parallel, latched and serial-addressable.
// Assumes all pins are asynchronous to clk and change slower than a few clk periods.
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Mode select low picks parallel interface, high picks serial-addressable interface.
// - In parallel operation seven weight inputs set the attenuation state.
// - Latched parallel: weights captured on the strobe pulse, held while strobe low.
// - Direct parallel: strobe held high, state follows the weight inputs at once.
// - Serial mode uses a 16-bit shift register: attenuation word and address word.
// - On latch, address word is compared to straps; mismatch keeps current state.
// - Host loads with strobe low, then pulses strobe high and low to latch.
// - Shift on serial clock rise while strobe low; transfer on strobe rise.
// - Serial or latched modes power up at maximum attenuation until a latch.
// - Direct mode powers up at maximum, waits the delay, then takes the weights.
// - Floating weight pins at power-up in direct mode settle at minimum attenuation.
// - An unconnected weight input reads as logic low.
// - After the first sequence, switching between modes is accepted freely.
// - Bits weigh 0.25 to 16 dB upward; all high is full range.
module step_attenuator
  import step_attenuator_pkg::*;
#(
  parameter int PUP_COUNT = PUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_serial,
  input wire logic latch_strobe,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic [6:0] parallel_weight_inputs,
  input wire logic [6:0] weight_pin_open,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [6:0] atten_state
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 4 + 2 * ATTEN_W + STRAP_W;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic le_d_r;
  logic sclk_d_r;
  logic [2:0] fill_r;

  assign pins_raw = {mode_serial, latch_strobe, serial_clk, serial_data,
                     parallel_weight_inputs, weight_pin_open,
                     addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      le_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
      fill_r <= '0;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      le_d_r <= sync2_r[SYNC_W-2];
      sclk_d_r <= sync2_r[SYNC_W-3];
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  logic mode_s;
  logic le_s;
  logic sclk_s;
  logic sdata_s;
  logic [6:0] weights_s;
  logic [6:0] open_s;
  logic [2:0] straps_s;
  logic [6:0] weights_eff;
  logic le_rise;
  logic sclk_rise;

  assign mode_s = sync2_r[SYNC_W-1];
  assign le_s = sync2_r[SYNC_W-2];
  assign sclk_s = sync2_r[SYNC_W-3];
  assign sdata_s = sync2_r[SYNC_W-4];
  assign weights_s = sync2_r[STRAP_W+2*ATTEN_W-1:STRAP_W+ATTEN_W];
  assign open_s = sync2_r[STRAP_W+ATTEN_W-1:STRAP_W];
  assign straps_s = sync2_r[STRAP_W-1:0];
  // Open pins are pulled low inside, so floating weights mean minimum loss
  assign weights_eff = weights_s & ~open_s;
  // Edges count only once the delay stage holds a real sample; a strobe tied
  // high would otherwise look like a rise right after reset
  assign le_rise = le_s & ~le_d_r & fill_r[2];
  assign sclk_rise = sclk_s & ~sclk_d_r & fill_r[2];

  function automatic logic addr_match(input logic [7:0] word, input logic [2:0] straps);
    addr_match = (word[STRAP_W-1:0] == straps);
  endfunction : addr_match

  // ---------------------------------------------------------------
  // Power-up delay
  // ---------------------------------------------------------------
  localparam int CNT_W = $clog2(PUP_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PUP_COUNT - 1);

  logic [CNT_W-1:0] pup_cnt_r;
  logic [CNT_W-1:0] pup_cnt_nxt;
  logic pup_done_r;
  logic pup_done_nxt;

  always_comb begin
    pup_cnt_nxt = pup_cnt_r;
    pup_done_nxt = pup_done_r;
    if (!pup_done_r) begin
      if (pup_cnt_r == CNT_LAST) begin
        pup_done_nxt = 1'b1;
      end else begin
        pup_cnt_nxt = pup_cnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pup_cnt_r <= '0;
      pup_done_r <= 1'b0;
    end else begin
      pup_cnt_r <= pup_cnt_nxt;
      pup_done_r <= pup_done_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Shift register and attenuator core state
  // ---------------------------------------------------------------
  logic [SHIFT_W-1:0] shreg_r;
  logic [SHIFT_W-1:0] shreg_nxt;
  logic [6:0] core_r;
  logic [6:0] core_nxt;
  logic hit_r;
  logic hit_nxt;

  always_comb begin
    shreg_nxt = shreg_r;
    core_nxt = core_r;
    hit_nxt = hit_r;
    if (mode_s) begin
      // Shift only while strobe low so the core never sees a half-loaded word
      if (sclk_rise && !le_s) begin
        shreg_nxt = {sdata_s, shreg_r[SHIFT_W-1:1]};
      end
      if (le_rise) begin
        hit_nxt = addr_match(shreg_r[SHIFT_W-1:ADDR_LSB], straps_s);
        if (hit_nxt) begin
          core_nxt = shreg_r[ATTEN_W-1:0];
        end
      end
    end else begin
      if (le_rise) begin
        core_nxt = weights_eff;
      end else if (le_s && pup_done_r) begin
        core_nxt = weights_eff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_r <= '0;
      core_r <= ATTEN_MAX;
      hit_r <= 1'b0;
    end else begin
      shreg_r <= shreg_nxt;
      core_r <= core_nxt;
      hit_r <= hit_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave: control and status
  // ---------------------------------------------------------------
  logic force_max_r;
  logic force_max_nxt;
  logic ack_nxt;
  logic [31:0] rdata_nxt;
  logic [6:0] atten_nxt;
  logic [31:0] status_word;

  assign status_word = {22'h00_0000, hit_r, pup_done_r, mode_s, core_r};

  always_comb begin
    force_max_nxt = force_max_r;
    ack_nxt = 1'b0;
    rdata_nxt = wb_dat_o;
    // Single-cycle ack, dropped after one cycle even if the master lingers
    if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      ack_nxt = 1'b1;
      rdata_nxt = WB_ZERO;
      case (wb_adr_i)
        REG_CTRL: begin
          if (wb_we_i && wb_sel_i[0]) begin
            force_max_nxt = wb_dat_i[CTRL_FORCE_MAX];
          end
          rdata_nxt[CTRL_FORCE_MAX] = force_max_r;
        end
        REG_STATUS: begin
          rdata_nxt = status_word;
        end
        default: begin
          rdata_nxt = WB_ZERO;
        end
      endcase
    end
    // Override only masks the output; the programmed state survives it
    atten_nxt = force_max_r ? ATTEN_MAX : core_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      force_max_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      atten_state <= ATTEN_MAX;
    end else begin
      force_max_r <= force_max_nxt;
      wb_ack_o <= ack_nxt;
      wb_dat_o <= rdata_nxt;
      atten_state <= atten_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_serial_shift_in: assert property (@(posedge clk) disable iff (!rst_n)
    mode_s && sclk_rise && !le_s |=>
      shreg_r == {$past(sdata_s), $past(shreg_r[SHIFT_W-1:1])})
    else $error("Shift register did not take serial bit");

  a_serial_latch_hit: assert property (@(posedge clk) disable iff (!rst_n)
    mode_s && le_rise && shreg_r[ADDR_LSB+STRAP_W-1:ADDR_LSB] == straps_s |=>
      core_r == $past(shreg_r[ATTEN_W-1:0]))
    else $error("Matching address did not update state");

  a_serial_latch_miss: assert property (@(posedge clk) disable iff (!rst_n)
    mode_s && le_rise && shreg_r[ADDR_LSB+STRAP_W-1:ADDR_LSB] != straps_s |=>
      $stable(core_r) && !hit_r)
    else $error("Mismatched address changed state");

  a_parallel_no_shift: assert property (@(posedge clk) disable iff (!rst_n)
    !mode_s |=> $stable(shreg_r))
    else $error("Shift register moved in parallel mode");

  a_serial_ignore_wts: assert property (@(posedge clk) disable iff (!rst_n)
    mode_s && !le_rise |=> $stable(core_r))
    else $error("State changed in serial mode without a latch");

  a_latched_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !mode_s && !le_s ##1 !mode_s && !le_s |-> $stable(core_r))
    else $error("Latched parallel state changed while strobe low");

  a_direct_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !mode_s && le_s && pup_done_r |=> core_r == $past(weights_eff))
    else $error("Direct parallel state did not follow weights");

  a_pup_max_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !pup_done_r && !le_rise && core_r == ATTEN_MAX |=>
      core_r == ATTEN_MAX)
    else $error("State left maximum during power-up delay");

  a_no_early_latch: assert property (@(posedge clk) disable iff (!rst_n)
    !fill_r[2] |=> core_r == ATTEN_MAX)
    else $error("State left maximum before pins were sampled");

  a_open_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
    !mode_s && le_rise |=> (core_r & $past(open_s)) == ATTEN_MIN)
    else $error("Open weight pin read as high");

  a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not a single-cycle pulse");

  a_force_output: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 atten_state == ($past(force_max_r) ? ATTEN_MAX : $past(core_r)))
    else $error("Output state does not match core or override");

endmodule : step_attenuator

`default_nettype wire

// ==== host_model.sv ====
// Host-side pin driver for the step attenuator control port.
// Assumes a free-running clk; every pin change lands just after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter logic [6:0] PRESET = 7'h35
) (
  input wire logic clk,
  output logic mode_serial,
  output logic latch_strobe,
  output logic serial_clk,
  output logic serial_data,
  output logic [6:0] parallel_weight_inputs,
  output logic [6:0] weight_pin_open
);
  // Pins preset before power-up: direct mode
  initial begin
    mode_serial = 1'b0;
    latch_strobe = 1'b1;
    serial_clk = 1'b0;
    serial_data = 1'b0;
    parallel_weight_inputs = PRESET;
    weight_pin_open = 7'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic set_pins(input logic ser, input logic le, input logic [6:0] w,
                          input logic [6:0] op);
    @(posedge clk);
    mode_serial <= ser;
    latch_strobe <= le;
    parallel_weight_inputs <= w;
    weight_pin_open <= op;
    tick(8);
  endtask : set_pins
  task automatic pulse_le();
    @(posedge clk);
    latch_strobe <= 1'b1;
    tick(8);
    latch_strobe <= 1'b0;
    tick(8);
  endtask : pulse_le
  // Link clock runs only inside a frame; data line toggles once released
  task automatic send_word(input logic [15:0] w);
    @(posedge clk);
    latch_strobe <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      serial_data <= (i == 7) ? 1'b0 : w[i];
      tick(4);
      serial_clk <= 1'b1;
      tick(4);
      serial_clk <= 1'b0;
    end
    serial_data <= ~w[15];
    tick(4);
    pulse_le();
  endtask : send_word
endmodule : host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the step attenuator control port.
// Assumes host_model drives the pins and a Wishbone master task here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import step_attenuator_pkg::*;
  localparam int PUP = 20;
  localparam logic [6:0] PRE = 7'h35;
  logic clk, rst_n, mode_serial, latch_strobe, serial_clk, serial_data;
  logic [6:0] parallel_weight_inputs, weight_pin_open, atten_state, w, op, exp_st;
  logic [2:0] strap;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
  logic [7:0] adr_b;
  int mismatches, n_compared;
  step_attenuator #(.PUP_COUNT(PUP)) u_dut (.clk(clk), .rst_n(rst_n),
    .mode_serial(mode_serial), .latch_strobe(latch_strobe), .serial_clk(serial_clk),
    .serial_data(serial_data), .parallel_weight_inputs(parallel_weight_inputs),
    .weight_pin_open(weight_pin_open), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .atten_state(atten_state));
  host_model #(.PRESET(PRE)) u_host (.clk(clk), .mode_serial(mode_serial),
    .latch_strobe(latch_strobe), .serial_clk(serial_clk), .serial_data(serial_data),
    .parallel_weight_inputs(parallel_weight_inputs), .weight_pin_open(weight_pin_open));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic end_sim();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    seed = 32'h0000_A476;
    strap = 3'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(atten_state, ATTEN_MAX);
    repeat (20) @(posedge clk);
    chk(atten_state, PRE);
    $display("test power_up done");
    for (int i = 0; i < 5; i++) begin
      w = 7'(rnd());
      op = (i == 4) ? 7'h7F : 7'(rnd());
      u_host.set_pins(1'b0, 1'b1, w, op);
      exp_st = w & ~op;
      chk(atten_state, exp_st);
    end
    $display("test direct done");
    w = 7'(rnd());
    u_host.set_pins(1'b0, 1'b0, w, 7'h00);
    chk(atten_state, exp_st);
    u_host.pulse_le();
    exp_st = w;
    chk(atten_state, exp_st);
    u_host.send_word(16'h00_7F);
    chk(atten_state, exp_st);
    $display("test latched done");
    strap <= 3'(rnd());
    u_host.set_pins(1'b1, 1'b0, 7'h00, 7'h00);
    for (int j = 0; j < 4; j++) begin
      w = 7'(rnd());
      adr_b = {5'(rnd()), (j == 2) ? ~strap : strap};
      u_host.send_word({adr_b, 1'b0, w});
      if (j != 2) exp_st = w;
      chk(atten_state, exp_st);
    end
    u_host.set_pins(1'b1, 1'b0, 7'(rnd()), 7'h00);
    chk(atten_state, exp_st);
    u_host.set_pins(1'b1, 1'b0, 7'h00, 7'h00);
    $display("test serial done");
    wb(1'b0, REG_STATUS, WB_ZERO);
    chk(rd, {22'h00_0000, 3'h7, exp_st});
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(atten_state, ATTEN_MAX);
    wb(1'b1, 4'hC, 32'h0000_0000);
    wb(1'b0, REG_CTRL, WB_ZERO);
    chk(rd, 32'h0000_0001);
    wb(1'b0, 4'h8, WB_ZERO);
    chk(rd, WB_ZERO);
    wb(1'b1, REG_CTRL, WB_ZERO);
    repeat (3) @(posedge clk);
    chk(atten_state, exp_st);
    $display("test registers done");
    w = 7'(rnd());
    u_host.set_pins(1'b0, 1'b1, w, 7'h00);
    chk(atten_state, w);
    $display("test mode_switch done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
